// ---- startup_pkg.sv ----
/*
  Shared constants and types for the start-up and configuration control block.
  Assumes a single 40 MHz clock, mclk, and an active-low asynchronous reset.
*/
`default_nettype none

package startup_pkg;
  localparam logic [13:0] CFG_ADDR = 14'h2007;
  localparam logic [13:0] TEST_LO = 14'h2000;
  localparam logic [13:0] TEST_HI = 14'h3FFF;
  localparam logic [13:0] CFG_ERASED = 14'h3FFF;
  localparam logic [13:0] READ_BLANK = 14'h0000;
  localparam int OSC_SEL_LSB = 0;
  localparam int DOG_EN_BIT = 2;
  localparam int PWRUP_EN_BIT = 3;
  localparam int CNT_W = 22;
  localparam int CLK_HZ = 40_000_000;
  localparam int PWRUP_MS = 72;
  localparam int PWRUP_CYCLES = PWRUP_MS * (CLK_HZ / 1000);
  localparam int OSC_WAIT_CYCLES = 1024;
  localparam int DOG_TICKS = 256;

  typedef enum logic [1:0] {
    OSC_LP = 2'h0,
    OSC_XT = 2'h1,
    OSC_HS = 2'h2,
    OSC_RC = 2'h3
  } osc_mode_e;

  typedef enum logic [1:0] {
    ST_PWR = 2'h0,
    ST_OSC = 2'h1,
    ST_RUN = 2'h2,
    ST_HALT = 2'h3
  } seq_state_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [13:0] addr;
    logic [13:0] data;
  } prog_req_s;

  typedef struct packed {
    osc_mode_e osc;
    logic dog_en;
    logic pwrup_en;
  } cfg_view_s;
endpackage : startup_pkg

`default_nettype wire

// ---- delay_counter.sv ----
/*
  Loadable down-counter with an expiry flag, used for each start-up delay and the watchdog.
  Assumes load and tick come from logic on mclk.
*/
`timescale 1ns/10ps
`default_nettype none

module delay_counter #(
  parameter logic [startup_pkg::CNT_W-1:0] RESET_VAL = 22'h000001
) (
  input wire logic mclk, // Clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic load, // Reload the count.
  input wire logic [startup_pkg::CNT_W-1:0] load_val, // Value to reload.
  input wire logic tick, // Count down one step.
  output logic expired // Count has reached zero.
);
  logic [startup_pkg::CNT_W-1:0] count_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= RESET_VAL;
    end else if (load) begin
      count_reg <= load_val;
    end else if (tick && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired = (count_reg == '0);
endmodule : delay_counter

`default_nettype wire

// ---- config_word_startup_control.sv ----
/*
  Start-up sequencer, configuration word store, watchdog and halt/wake control.
  Assumes arst_n is the power-on reset; pins and the watchdog oscillator are asynchronous.
*/
// Overview of operation
// - Programmed bit reads zero, erased reads one.
// - Configuration word lives at address 2007h.
// - Test space 2000h-3FFFh reachable only programming.
// - Watchdog disabled only by configuration bit.
// - Watchdog counts its own RC oscillator.
// - Oscillator start-up timer holds reset until stable in LP, XT and HS modes; RC mode skips it.
// - Power-up timer 72 ms never runs: power-on reset leaves configuration bit 3 erased, which disables it.
// - Halt ends on reset, watchdog, interrupt.
// - Two select bits choose four oscillator modes.
`timescale 1ns/10ps
`default_nettype none

module config_word_startup_control #(
  parameter int PWRUP_CYCLES = startup_pkg::PWRUP_CYCLES
) (
  input wire logic mclk, // 40 MHz clock.
  input wire logic arst_n, // Power-on reset, active low.
  input wire logic ext_reset_n, // External reset pin, active low.
  input wire logic prog_mode, // Programming-mode pin, high while programming.
  input wire logic dog_osc, // Watchdog RC oscillator.
  input wire startup_pkg::prog_req_s prog_req, // Programmer access.
  input wire logic [13:0] cpu_addr, // Running-program memory address.
  input wire logic cpu_rd, // Running-program read strobe.
  input wire logic cpu_sleep, // Halt request pulse.
  input wire logic cpu_clrwdt, // Watchdog clear pulse.
  input wire logic irq_pending, // Enabled interrupt pending.
  output logic cpu_reset_n, // Core reset, active low.
  output logic halted, // Core in low-power halt.
  output startup_pkg::osc_mode_e osc_mode, // Selected oscillator mode.
  output logic dog_timeout, // Watchdog time-out pulse.
  output logic [13:0] prog_rdata, // Programmer read data.
  output logic cpu_space_fault // Program touched the test space.
);
  localparam int W = startup_pkg::CNT_W;
  localparam logic [W-1:0] PWRUP_LOAD = W'(PWRUP_CYCLES - 1);
  localparam logic [W-1:0] OSC_WAIT_LOAD = W'(startup_pkg::OSC_WAIT_CYCLES - 1);
  localparam logic [W-1:0] DOG_LOAD = W'(startup_pkg::DOG_TICKS - 1);

  logic ext_s1_reg, ext_s2_reg, prog_s1_reg, prog_s2_reg;
  logic wdo_s1_reg, wdo_s2_reg, wdo_s3_reg;
  logic [13:0] cfg_reg, cfg_next;
  logic [13:0] rdata_next;
  logic rst_out_reg, halt_out_reg, dog_to_reg, fault_reg;
  startup_pkg::seq_state_e state_reg, state_next;
  startup_pkg::cfg_view_s cfg;

  // Pins are re-timed before any decision is taken on them.
  // The reset pin synchroniser starts at the pin's idle level, so release of the
  // power-on reset does not look like an external reset.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      prog_s1_reg <= 1'b0;
      prog_s2_reg <= 1'b0;
      wdo_s1_reg <= 1'b0;
      wdo_s2_reg <= 1'b0;
      wdo_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_reset_n;
      ext_s2_reg <= ext_s1_reg;
      prog_s1_reg <= prog_mode;
      prog_s2_reg <= prog_s1_reg;
      wdo_s1_reg <= dog_osc;
      wdo_s2_reg <= wdo_s1_reg;
      wdo_s3_reg <= wdo_s2_reg;
    end
  end

  wire ext_rst = !ext_s2_reg;
  wire in_prog = prog_s2_reg;
  // Only the second and third stages are read, so a metastable first stage never reaches logic.
  wire dog_tick = wdo_s2_reg && !wdo_s3_reg;

  // An erased word reads all ones; programming can only clear bits, as in EPROM.
  wire cfg_hit = (prog_req.addr == startup_pkg::CFG_ADDR);
  wire test_lo_ok = (prog_req.addr >= startup_pkg::TEST_LO);
  wire test_hi_ok = (prog_req.addr <= startup_pkg::TEST_HI);
  wire test_hit = test_lo_ok && test_hi_ok;
  wire cfg_wr = in_prog && prog_req.wr && cfg_hit;
  assign cfg_next = cfg_wr ? (cfg_reg & prog_req.data) : cfg_reg;
  assign rdata_next = (in_prog && prog_req.rd && cfg_hit) ? cfg_reg :
                      (in_prog && prog_req.rd && test_hit) ? startup_pkg::CFG_ERASED :
                      startup_pkg::READ_BLANK;
  wire cpu_test = cpu_rd && (cpu_addr >= startup_pkg::TEST_LO) &&
                  (cpu_addr <= startup_pkg::TEST_HI);

  assign cfg.osc = startup_pkg::osc_mode_e'(cfg_reg[startup_pkg::OSC_SEL_LSB +: 2]);
  assign cfg.dog_en = cfg_reg[startup_pkg::DOG_EN_BIT];
  assign cfg.pwrup_en = !cfg_reg[startup_pkg::PWRUP_EN_BIT];

  logic pwrup_done, ost_done, dog_done;
  wire hold = ext_rst || in_prog;
  // Software can only clear the count; nothing but the configuration bit stops a time-out.
  wire dog_fire = cfg.dog_en && dog_tick && dog_done;
  wire dog_clr = cpu_clrwdt || cpu_sleep || !rst_out_reg || dog_fire;
  wire ost_skip = (cfg.osc == startup_pkg::OSC_RC);
  wire next_is_osc = (state_next == startup_pkg::ST_OSC);
  wire ost_load = next_is_osc && (state_reg != startup_pkg::ST_OSC || hold);
  wire pwrup_tick = (state_reg == startup_pkg::ST_PWR);
  wire ost_tick = (state_reg == startup_pkg::ST_OSC);

  // The power-up delay counter is only reloaded by the power-on reset itself.
  delay_counter #(.RESET_VAL(PWRUP_LOAD)) u_pwrup (
    .mclk(mclk), .arst_n(arst_n), .load(1'b0), .load_val(PWRUP_LOAD),
    .tick(pwrup_tick), .expired(pwrup_done)
  );
  delay_counter #(.RESET_VAL(OSC_WAIT_LOAD)) u_ost (
    .mclk(mclk), .arst_n(arst_n), .load(ost_load), .load_val(OSC_WAIT_LOAD),
    .tick(ost_tick), .expired(ost_done)
  );
  delay_counter #(.RESET_VAL(DOG_LOAD)) u_dog (
    .mclk(mclk), .arst_n(arst_n), .load(dog_clr), .load_val(DOG_LOAD),
    .tick(dog_tick), .expired(dog_done)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      startup_pkg::ST_PWR: begin
        if (!cfg.pwrup_en || pwrup_done) begin
          state_next = startup_pkg::ST_OSC;
        end
      end
      startup_pkg::ST_OSC: begin
        if (!hold && (ost_skip || ost_done)) begin
          state_next = startup_pkg::ST_RUN;
        end
      end
      startup_pkg::ST_RUN: begin
        if (hold || dog_fire) begin
          state_next = startup_pkg::ST_OSC;
        end else if (cpu_sleep) begin
          state_next = startup_pkg::ST_HALT;
        end
      end
      startup_pkg::ST_HALT: begin
        if (hold) begin
          state_next = startup_pkg::ST_OSC;
        end else if (dog_fire || irq_pending) begin
          state_next = startup_pkg::ST_RUN;
        end
      end
      default: state_next = startup_pkg::ST_PWR;
    endcase
  end

  // The core leaves reset only in the states where every enabled delay is over.
  wire next_live = (state_next == startup_pkg::ST_RUN) || (state_next == startup_pkg::ST_HALT);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= startup_pkg::ST_PWR;
      cfg_reg <= startup_pkg::CFG_ERASED;
      rst_out_reg <= 1'b0;
      halt_out_reg <= 1'b0;
      dog_to_reg <= 1'b0;
      fault_reg <= 1'b0;
      prog_rdata <= startup_pkg::READ_BLANK;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      rst_out_reg <= next_live;
      halt_out_reg <= (state_next == startup_pkg::ST_HALT);
      dog_to_reg <= dog_fire;
      fault_reg <= cpu_test;
      prog_rdata <= rdata_next;
    end
  end

  assign cpu_reset_n = rst_out_reg;
  assign halted = halt_out_reg;
  assign osc_mode = cfg.osc;
  assign dog_timeout = dog_to_reg;
  assign cpu_space_fault = fault_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_run_entry;
    state_reg != startup_pkg::ST_RUN && state_reg != startup_pkg::ST_HALT ##1
    state_reg == startup_pkg::ST_RUN;
  endsequence

  wire in_run = (state_reg == startup_pkg::ST_RUN);
  wire in_halt = (state_reg == startup_pkg::ST_HALT);
  wire in_osc = (state_reg == startup_pkg::ST_OSC);
  wire prog_cfg_rd = in_prog && prog_req.rd && cfg_hit;

  chk_prog_only_write: assert property (!in_prog |=> cfg_reg == $past(cfg_reg))
    else $error("Configuration word changed outside programming.");
  chk_bits_only_clear: assert property (cfg_wr |=>
    cfg_reg == ($past(cfg_reg) & $past(prog_req.data)))
    else $error("Programming did not clear bits as written.");
  chk_cfg_readback: assert property (prog_cfg_rd |=> prog_rdata == $past(cfg_reg))
    else $error("Configuration word not read back at its address.");
  chk_cpu_fault_flag: assert property (cpu_test |=> cpu_space_fault)
    else $error("Program access to test space not flagged.");
  chk_fault_clears: assert property (!cpu_test |=> !cpu_space_fault)
    else $error("Test space flag raised without a program access.");
  chk_pwrup_gate: assert property (state_reg == startup_pkg::ST_PWR && cfg.pwrup_en &&
    !pwrup_done |=> state_reg == startup_pkg::ST_PWR)
    else $error("Power-up delay left early.");
  chk_ost_gate: assert property (s_run_entry |-> $past(ost_done || ost_skip))
    else $error("Run entered before oscillator start-up expired.");
  chk_ost_hold: assert property (in_osc && !ost_skip && !ost_done |=> !in_run)
    else $error("Oscillator start-up wait cut short.");
  chk_release_delays: assert property (s_run_entry |-> cpu_reset_n && !$past(hold))
    else $error("Core reset not released after start-up.");
  chk_dog_resets: assert property (in_run && dog_fire && !hold |=>
    in_osc && !cpu_reset_n)
    else $error("Watchdog time-out did not reset the core.");
  chk_dog_off: assert property (!cfg.dog_en |-> !dog_fire ##1 !dog_timeout)
    else $error("Watchdog fired while disabled.");
  chk_sleep_halts: assert property (in_run && cpu_sleep && !hold && !dog_fire |=>
    in_halt && halted)
    else $error("Halt request not taken.");
  chk_irq_wake: assert property (in_halt && irq_pending && !hold |=>
    in_run && !halted)
    else $error("Interrupt did not end halt.");
  chk_osc_decode: assert property (osc_mode == startup_pkg::osc_mode_e'(cfg_reg[1:0]))
    else $error("Oscillator mode does not follow select bits.");
endmodule : config_word_startup_control

`default_nettype wire

// ---- unused_placeholder_none.sv ----
`timescale 1ns/10ps

// ---- prog_model.sv ----
/*
  Programmer model: drives the programming-mode pin and word accesses.
  Assumes the bench calls its tasks and shares mclk with the design.
*/
`timescale 1ns/10ps
`default_nettype none

module prog_model (
  input wire logic mclk, // Clock.
  output startup_pkg::prog_req_s req, // Access to the device.
  output logic mode // Programming-mode pin.
);
  initial begin
    mode = 1'b0;
    req = '0;
  end

  // Waits past the two-stage pin synchroniser before any access.
  task automatic set_mode(input logic on);
    @(posedge mclk);
    mode <= on;
    repeat (4) @(posedge mclk);
  endtask : set_mode

  // Released address and data lines show the inverse and the strobes drop, so a stale value is never mistaken for live data.
  task automatic acc(input logic rd, input logic wr, input logic [13:0] a,
                     input logic [13:0] d);
    @(posedge mclk);
    req <= '{rd: rd, wr: wr, addr: a, data: d};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, data: ~d};
  endtask : acc
endmodule : prog_model

`default_nettype wire

// ---- config_word_startup_control_tb.sv ----
/*
  Self-checking bench for the start-up and configuration control block.
  Assumes prog_model drives the programmer side; power-up delay shortened.
*/
`timescale 1ns/10ps
`default_nettype none

module config_word_startup_control_tb;
  localparam int PWRUP_SIM = 50;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ext_reset_n = 1'b1;
  logic prog_mode;
  logic dog_osc = 1'b0;
  logic dog_run = 1'b0;
  startup_pkg::prog_req_s prog_req;
  logic [13:0] cpu_addr = 14'h0000;
  logic cpu_rd = 1'b0;
  logic cpu_sleep = 1'b0;
  logic cpu_clrwdt = 1'b0;
  logic irq_pending = 1'b0;
  logic cpu_reset_n, halted, dog_timeout, cpu_space_fault, seen;
  startup_pkg::osc_mode_e osc_mode;
  logic [13:0] prog_rdata, a;
  logic [31:0] seed = 32'h8251F064;
  logic [1:0] dog_div = 2'h0;
  int n_errors = 0;
  int cmp_count = 0;
  int n;

  always #12.5 mclk = ~mclk;

  // Watchdog oscillator ticks every 8 mclk cycles, well below the sync limit.
  always @(posedge mclk) begin
    dog_div <= dog_div + 2'h1;
    if (dog_run && dog_div == 2'h3) dog_osc <= ~dog_osc;
  end

  prog_model i_prog_model (.mclk(mclk), .req(prog_req), .mode(prog_mode));

  config_word_startup_control #(.PWRUP_CYCLES(PWRUP_SIM)) i_config_word_startup_control (
    .mclk(mclk), .arst_n(arst_n), .ext_reset_n(ext_reset_n), .prog_mode(prog_mode),
    .dog_osc(dog_osc), .prog_req(prog_req), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_sleep(cpu_sleep), .cpu_clrwdt(cpu_clrwdt), .irq_pending(irq_pending),
    .cpu_reset_n(cpu_reset_n), .halted(halted), .osc_mode(osc_mode),
    .dog_timeout(dog_timeout), .prog_rdata(prog_rdata), .cpu_space_fault(cpu_space_fault));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic pick(input int sel);
    return (sel == 0) ? cpu_reset_n : (sel == 1) ? halted : dog_timeout;
  endfunction : pick

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_until(input int sel, input logic lvl, input int lim);
    n = 0;
    while (pick(sel) !== lvl) begin
      @(posedge mclk);
      #1;
      n++;
      if (n >= lim) begin
        n_errors++;
        $display("unexpected at %0t: wait %0d ran out", $time, sel);
        tally_and_finish();
      end
    end
  endtask : wait_until

  task automatic por;
    arst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
  endtask : por

  task automatic pulse_sleep;
    @(posedge mclk);
    cpu_sleep <= 1'b1;
    @(posedge mclk);
    cpu_sleep <= 1'b0;
    #1;
    check({13'h0000, halted}, 14'h0001);
  endtask : pulse_sleep

  initial begin
    por();
    wait_until(0, 1'b1, 20);
    check({12'h000, osc_mode}, {12'h000, startup_pkg::OSC_RC});
    for (int i = 0; i < 44; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 14'h1FFF : (i == 1) ? 14'h2000 : (i == 2) ? 14'h3FFF : seed[13:0];
      @(posedge mclk);
      cpu_rd <= 1'b1;
      cpu_addr <= a;
      @(posedge mclk);
      cpu_rd <= 1'b0;
      #1;
      check({13'h0000, cpu_space_fault}, {13'h0000, a >= 14'h2000});
    end
    i_prog_model.acc(1'b0, 1'b1, startup_pkg::CFG_ADDR, 14'h0000);
    #1;
    check({12'h000, osc_mode}, {12'h000, startup_pkg::OSC_RC});
    i_prog_model.acc(1'b1, 1'b0, startup_pkg::CFG_ADDR, 14'h0000);
    #1;
    check(prog_rdata, 14'h0000);
    for (int m = 0; m < 4; m++) begin
      por();
      i_prog_model.set_mode(1'b1);
      a = {10'h3FF, 2'b10, m[1:0]};
      i_prog_model.acc(1'b0, 1'b1, startup_pkg::CFG_ADDR, a);
      #1;
      check({12'h000, osc_mode}, {12'h000, m[1:0]});
      i_prog_model.acc(1'b1, 1'b0, startup_pkg::CFG_ADDR, 14'h0000);
      #1;
      check(prog_rdata, a);
      i_prog_model.acc(1'b1, 1'b0, 14'h2000 + 14'(m), 14'h0000);
      #1;
      check(prog_rdata, 14'h3FFF);
      i_prog_model.set_mode(1'b0);
      wait_until(0, 1'b1, 1100);
      check({13'h0000, n > 900}, {13'h0000, m != 3});
      seen = 1'b0;
      dog_run <= 1'b1;
      repeat (2600) begin
        @(posedge mclk);
        #1;
        if (dog_timeout === 1'b1) seen = 1'b1;
      end
      dog_run <= 1'b0;
      check({13'h0000, seen}, 14'h0000);
    end
    por();
    wait_until(0, 1'b1, 20);
    dog_run <= 1'b1;
    wait_until(2, 1'b1, 2200);
    check({13'h0000, n > 2000}, 14'h0001);
    check({13'h0000, cpu_reset_n}, 14'h0000);
    wait_until(0, 1'b1, 20);
    pulse_sleep();
    repeat (3) @(posedge mclk);
    irq_pending <= 1'b1;
    wait_until(1, 1'b0, 4);
    irq_pending <= 1'b0;
    pulse_sleep();
    wait_until(1, 1'b0, 2200);
    check({13'h0000, cpu_reset_n}, 14'h0001);
    pulse_sleep();
    ext_reset_n <= 1'b0;
    wait_until(0, 1'b0, 8);
    check({13'h0000, halted}, 14'h0000);
    ext_reset_n <= 1'b1;
    wait_until(0, 1'b1, 20);
    dog_run <= 1'b0;
    tally_and_finish();
  end
endmodule : config_word_startup_control_tb

`default_nettype wire
